// file: rtl/interrupt_request_and_master_enable.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "irq_ctrl_map.svh"
// Functional notes
// - A peripheral request sets its request bit, held regardless of master enable.
// - With master enable set, any pending request is forwarded to the core.
// - With master enable clear, nothing is forwarded; request register stays readable.
// - Request bits: 7 timer2, 6 timer1, 5 timer0, 4 rx, 3 tx, 2 i2c, 1 spi, 0 adc.
// - Master enable bit 7 is set by enable, return instruction, or writing 1.
// - Master enable cleared by disable, core acknowledge, reset, or writing 0.
// - Control bits 6 to 0 read zero; software writes zero to them.
// - Select bit 5 picks port A pin 5 (0) or comparator 1 (1).
// - Select bits 4 to 1 pick port A pin x (0) or port D pin x (1).
module interrupt_request_and_master_enable
  import irq_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire apb_req_type apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] periphReq,
  input wire core_cmd_type coreCmd,
  output logic coreIrq,
  input wire logic [5:1] portAPins,
  input wire logic [4:1] portDPins,
  input wire logic comparator1Out,
  output logic [5:1] sharedReq,
  output logic intOut
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic reg_sel_type decodeReg(input logic [15:0] addr);
    reg_sel_type sel;
    sel = SEL_NONE;
    if (addr == {2'b00, `REQ_IDX, 2'b00}) sel = SEL_REQ;
    else if (addr == {2'b00, `CTL_IDX, 2'b00}) sel = SEL_CTL;
    else if (addr == {2'b00, `SEL_IDX, 2'b00}) sel = SEL_SRC;
    else if (addr == {2'b00, `EVT_STAT_IDX, 2'b00}) sel = SEL_EVT_STAT;
    else if (addr == {2'b00, `EVT_EN_IDX, 2'b00}) sel = SEL_EVT_EN;
    else if (addr == {2'b00, `EVT_CLR_IDX, 2'b00}) sel = SEL_EVT_CLR;
    return sel;
  endfunction : decodeReg

  reg_sel_type regSel;
  logic setupPhase;
  logic accessPhase;
  logic wrStrobe;
  logic reqWrite;
  logic ctlWrite;
  logic srcWrite;
  logic evtEnWrite;
  logic evtClrWrite;

  assign regSel = decodeReg(apbReq.paddr);
  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessPhase = apbReq.psel && apbReq.penable;
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wrStrobe = accessPhase && apbReq.pwrite;
  assign reqWrite = wrStrobe && (regSel == SEL_REQ);
  assign ctlWrite = wrStrobe && (regSel == SEL_CTL);
  assign srcWrite = wrStrobe && (regSel == SEL_SRC);
  assign evtEnWrite = wrStrobe && (regSel == SEL_EVT_EN);
  assign evtClrWrite = wrStrobe && (regSel == SEL_EVT_CLR);
  assign pslverr = accessPhase && (regSel == SEL_NONE);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Ports A, D and the comparator are asynchronous to ref_clk
  logic [9:0] pinMeta_q;
  logic [9:0] pinSync_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinMeta_q <= 10'h000;
      pinSync_q <= 10'h000;
    end else begin
      pinMeta_q <= {comparator1Out, portDPins, portAPins};
      pinSync_q <= pinMeta_q;
    end
  end

  logic [5:1] paSync;
  logic [4:1] pdSync;
  logic compSync;

  assign paSync = pinSync_q[4:0];
  assign pdSync = pinSync_q[8:5];
  assign compSync = pinSync_q[9];

  // ****************************************
  // Source select register
  // ****************************************
  logic [7:0] srcSel_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      srcSel_q <= `SEL_RESET;
    end else if (srcWrite) begin
      // Bits 7, 6 and 0 are reserved and stay zero
      srcSel_q <= apbReq.pwdata[7:0] & `SEL_MASK;
    end
  end

  // ****************************************
  // Shared request muxes
  // ****************************************
  logic [5:1] sharedReq_d;
  logic [5:1] sharedReq_q;

  genvar x;
  generate
    for (x = 1; x <= 4; x++) begin : g_padx
      assign sharedReq_d[x] = srcSel_q[x] ? pdSync[x] : paSync[x];
    end
  endgenerate

  assign sharedReq_d[5] = srcSel_q[`PA5_SEL_BIT] ? compSync : paSync[5];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sharedReq_q <= 5'h00;
    end else begin
      sharedReq_q <= sharedReq_d;
    end
  end

  assign sharedReq = sharedReq_q;

  // ****************************************
  // Request register
  // ****************************************
  logic [7:0] req_q;
  logic [7:0] req_d;

  always_comb begin
    req_d = req_q;
    if (reqWrite) begin
      req_d = apbReq.pwdata[7:0];
    end
    // A request in the same cycle overrides the software write
    req_d = req_d | periphReq;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_q <= `REQ_RESET;
    end else begin
      req_q <= req_d;
    end
  end

  // ****************************************
  // Master enable
  // ****************************************
  // Reset state is taken from the map so the field position and value stay in one place
  localparam logic [7:0] CtlResetVal = `CTL_RESET;
  logic enable_q;
  logic ackTake;
  logic enSet;
  logic enClr;

  assign ackTake = coreCmd.ack && coreIrq;
  assign enSet = coreCmd.enableExec || coreCmd.returnExec
    || (ctlWrite && apbReq.pwdata[`ME_BIT]);
  assign enClr = coreCmd.disableExec || ackTake
    || (ctlWrite && !apbReq.pwdata[`ME_BIT]);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_q <= CtlResetVal[`ME_BIT];
    end else if (enClr) begin
      // Disable wins so a racing acknowledge can never leave nesting open
      enable_q <= 1'b0;
    end else if (enSet) begin
      enable_q <= 1'b1;
    end
  end

  // Forwarded only while vectored operation is enabled
  assign coreIrq = enable_q && (|req_q);

  // ****************************************
  // Event status, enable and output
  // ****************************************
  logic [2:0] evtStat_q;
  logic [2:0] evtEn_q;
  logic [2:0] evtNow;

  assign evtNow[`EVT_NEW_REQ_BIT] = |(periphReq & ~req_q);
  assign evtNow[`EVT_ACK_BIT] = ackTake;
  assign evtNow[`EVT_SHARED_BIT] = |(sharedReq_d & ~sharedReq_q);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evtStat_q <= `EVT_RESET;
    end else begin
      // Set wins over a same-cycle clear
      evtStat_q <= (evtStat_q & ~(evtClrWrite ? apbReq.pwdata[2:0] : 3'h0)) | evtNow;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      evtEn_q <= `EVT_RESET;
    end else if (evtEnWrite) begin
      evtEn_q <= apbReq.pwdata[2:0];
    end
  end

  assign intOut = |(evtStat_q & evtEn_q);

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (regSel)
      SEL_REQ: rdata_d[7:0] = req_q;
      SEL_CTL: rdata_d[7:0] = {enable_q, 7'h00};
      SEL_SRC: rdata_d[7:0] = srcSel_q;
      SEL_EVT_STAT: rdata_d[2:0] = evtStat_q;
      SEL_EVT_EN: rdata_d[2:0] = evtEn_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Captured in the setup cycle so the data stands through the access cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (setupPhase) begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_request_sticky: assert property (
    !reqWrite |=> ((req_q & $past(req_q)) == $past(req_q)))
    else $error("request bit lost without a write");

  a_request_capture: assert property (
    (|periphReq) |=> ((req_q & $past(periphReq)) == $past(periphReq)))
    else $error("peripheral request not latched");

  // Checked one cycle on, so a broken enable or request path cannot satisfy it by itself
  a_forward_vectored: assert property (
    (enable_q && !enClr && !reqWrite && (|req_q)) |=> coreIrq)
    else $error("pending request not forwarded");

  a_polled_quiet: assert property (
    (!enable_q && !enSet) |=> !coreIrq)
    else $error("request forwarded while disabled");

  a_request_read: assert property (
    (setupPhase && regSel == SEL_REQ) |=> (prdata == {24'h000000, $past(req_q)}))
    else $error("request register read mismatch");

  a_enable_set: assert property (
    (coreCmd.enableExec && !enClr) |=> enable_q ##1 (enable_q || $past(enClr)))
    else $error("enable instruction did not set enable");

  a_enable_clear: assert property (
    coreCmd.disableExec |=> !enable_q && !coreIrq)
    else $error("disable instruction did not clear enable");

  a_ctl_reserved: assert property (
    (setupPhase && regSel == SEL_CTL) |=> (prdata[6:0] == 7'h00 && prdata[31:8] == 24'h0))
    else $error("control reserved bits not zero");

  a_pa5_select: assert property (
    1'b1 |=> sharedReq[5] == ($past(srcSel_q[5]) ? $past(compSync) : $past(paSync[5])))
    else $error("shared bit 5 source wrong");

  a_padx_select: assert property (
    1'b1 |=> sharedReq[4:1] == (($past(srcSel_q[4:1]) & $past(pdSync))
      | (~$past(srcSel_q[4:1]) & $past(paSync[4:1]))))
    else $error("shared port select wrong");

  a_ack_blocks: assert property (
    (coreCmd.ack && coreIrq) |=> !enable_q && !coreIrq)
    else $error("acknowledge did not block nesting");

  a_event_irq: assert property (
    ackTake && evtEn_q[`EVT_ACK_BIT] && !evtEnWrite |=> intOut)
    else $error("enabled event did not raise interrupt");

  a_return_set: assert property (
    (coreCmd.returnExec && !enClr) |=> enable_q)
    else $error("return instruction did not set enable");

  a_write_set: assert property (
    (ctlWrite && apbReq.pwdata[`ME_BIT] && !coreCmd.disableExec && !ackTake) |=> enable_q)
    else $error("write of one did not set enable");

  a_write_clear: assert property (
    (ctlWrite && !apbReq.pwdata[`ME_BIT]) |=> !enable_q)
    else $error("write of zero did not clear enable");

  a_request_write: assert property (
    reqWrite |=> (req_q == ($past(apbReq.pwdata[7:0]) | $past(periphReq))))
    else $error("request write or precedence wrong");

  a_source_reserved: assert property (
    srcWrite |=> ((srcSel_q & ~`SEL_MASK) == 8'h00))
    else $error("reserved select bits not zero");

  // ****************************************
  // Event flag checks
  // ****************************************
  a_event_sticky: assert property (
    !evtClrWrite |=> ((evtStat_q & $past(evtStat_q)) == $past(evtStat_q)))
    else $error("event flag lost without a clear");

  a_event_clear: assert property (
    (evtClrWrite && (evtNow == 3'h0)) |=> ((evtStat_q & $past(apbReq.pwdata[2:0])) == 3'h0))
    else $error("event flag not cleared");

  a_ack_event: assert property (
    ackTake |=> evtStat_q[`EVT_ACK_BIT])
    else $error("acknowledge event not flagged");

  a_new_request_event: assert property (
    (|(periphReq & ~req_q)) |=> evtStat_q[`EVT_NEW_REQ_BIT])
    else $error("new request event not flagged");

  // Shared pins are synchronised first, so the flag sets on the same edge that the shared output rises
  a_shared_event: assert property (
    (|(sharedReq_d & ~sharedReq_q)) |=> evtStat_q[`EVT_SHARED_BIT])
    else $error("shared request event not flagged");

endmodule : interrupt_request_and_master_enable

// file: rtl/irq_ctrl_map.svh
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define REQ_IDX 12'hFC0
`define CTL_IDX 12'hFCF
`define SEL_IDX 12'hFD0
`define EVT_STAT_IDX 12'hFD1
`define EVT_EN_IDX 12'hFD2
`define EVT_CLR_IDX 12'hFD3

// ****************************************
// Field positions
// ****************************************
`define ME_BIT 7
`define PA5_SEL_BIT 5
`define EVT_NEW_REQ_BIT 0
`define EVT_ACK_BIT 1
`define EVT_SHARED_BIT 2

// ****************************************
// Reset values and masks
// ****************************************
`define REQ_RESET 8'h00
`define CTL_RESET 8'h00
`define SEL_RESET 8'h00
`define SEL_MASK 8'h3E
`define EVT_RESET 3'h0

`endif

// file: rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // ****************************************
  // Bus and core carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic enableExec;
    logic disableExec;
    logic returnExec;
    logic ack;
  } core_cmd_type;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_REQ = 3'b001,
    SEL_CTL = 3'b010,
    SEL_SRC = 3'b011,
    SEL_EVT_STAT = 3'b100,
    SEL_EVT_EN = 3'b101,
    SEL_EVT_CLR = 3'b110
  } reg_sel_type;

endpackage : irq_ctrl_pkg

// file: tb/core_model.sv
`timescale 1ns/1ns
// ****************************************
// Core side: instruction pulses and acknowledge
// ****************************************
module core_model
  import irq_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic coreIrq,
  input wire logic [2:0] instr,
  input wire logic [3:0] ackDelay,
  output core_cmd_type coreCmd
);
  logic [3:0] wait_q;
  logic ack_q;
  // One pulse per request; the count saturates so a slow core still acks
  always @(posedge ref_clk) begin
    if (rst || !coreIrq || ack_q) begin
      wait_q <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      wait_q <= wait_q + 4'(wait_q != 4'hF);
      ack_q <= (wait_q >= ackDelay);
    end
  end
  assign coreCmd = {instr, ack_q};
endmodule : core_model

// file: tb/interrupt_request_and_master_enable_tb_top.sv
`timescale 1ns/1ns
`include "irq_ctrl_map.svh"
// ****************************************
// Bench top
// ****************************************
module interrupt_request_and_master_enable_tb_top
  import irq_ctrl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  apb_req_type apbReq = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, coreIrq, intOut, comparator1Out = 1'b0;
  logic [7:0] periphReq = 8'h00, v;
  logic [2:0] instr = 3'h0;
  logic [3:0] ackDelay = 4'hF;
  logic [5:1] portAPins = 5'h00, sharedReq;
  logic [4:1] portDPins = 4'h0;
  core_cmd_type coreCmd;
  integer seed = 80;
  int miscompares = 0, totalChecks = 0, cycles = 0;

  interrupt_request_and_master_enable dut_u (.ref_clk(ref_clk), .rst(rst),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periphReq(periphReq), .coreCmd(coreCmd), .coreIrq(coreIrq),
    .portAPins(portAPins), .portDPins(portDPins),
    .comparator1Out(comparator1Out), .sharedReq(sharedReq), .intOut(intOut));
  core_model core_u (.ref_clk(ref_clk), .rst(rst), .coreIrq(coreIrq),
    .instr(instr), .ackDelay(ackDelay), .coreCmd(coreCmd));

  always #5 ref_clk = ~ref_clk;
  // A hang counts against the run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tallyAndFinish();
    end
  end

  task tallyAndFinish;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tallyAndFinish

  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task xfer(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, idx, 2'b00}, pwdata: d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
  endtask : xfer

  task pulse(input logic [7:0] p);
    @(posedge ref_clk);
    periphReq <= p;
    @(posedge ref_clk);
    periphReq <= 8'h00;
  endtask : pulse

  task instrPulse(input logic [2:0] p);
    @(posedge ref_clk);
    instr <= p;
    @(posedge ref_clk);
    instr <= 3'h0;
    #1;
  endtask : instrPulse

  function logic [5:1] shExp(logic [7:0] s, logic [5:1] a, logic [4:1] d, logic c);
    shExp[5] = s[5] ? c : a[5];
    for (int i = 1; i < 5; i++) shExp[i] = s[i] ? d[i] : a[i];
  endfunction : shExp

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    xfer(0, `REQ_IDX, 0); chk(rd, 0);
    xfer(0, `CTL_IDX, 0); chk(rd, 0);
    xfer(0, 12'h100, 0); chk({rd[30:0], err}, 1);
    xfer(1, `CTL_IDX, 32'h80); xfer(0, `CTL_IDX, 0); chk(rd, 32'h80);
    xfer(1, `CTL_IDX, 0); xfer(0, `CTL_IDX, 0); chk(rd, 0);
    xfer(1, `EVT_EN_IDX, 32'h7);
    for (int i = 0; i < 12; i++) begin
      v = (i < 8) ? 8'h01 << i : 8'($random(seed));
      pulse(v);
      xfer(0, `REQ_IDX, 0); chk(rd, {24'h0, v});
      chk(coreIrq, 0);
      xfer(1, `REQ_IDX, 0);
    end
    #1 chk(intOut, 1);
    xfer(1, `EVT_EN_IDX, 0); #1 chk(intOut, 0);
    xfer(1, `EVT_CLR_IDX, 32'h7); xfer(0, `EVT_STAT_IDX, 0); chk(rd, 0);
    xfer(0, `EVT_CLR_IDX, 0); chk(rd, 0);
    periphReq <= 8'h10;
    xfer(1, `REQ_IDX, 0);
    periphReq <= 8'h00;
    xfer(0, `REQ_IDX, 0); chk(rd, 32'h10);
    pulse(8'h80);
    xfer(1, `CTL_IDX, 32'h80); #1 chk(coreIrq, 1);
    instrPulse(3'h2); chk(coreIrq, 0);
    instrPulse(3'h4); chk(coreIrq, 1);
    instrPulse(3'h2); instrPulse(3'h1); chk(coreIrq, 1);
    instrPulse(3'h2);
    ackDelay <= 4'h0;
    instrPulse(3'h4); chk(coreIrq, 1);
    @(posedge ref_clk); #1 chk(coreIrq, 1);
    @(posedge ref_clk); #1 chk(coreIrq, 0);
    xfer(0, `CTL_IDX, 0); chk(rd, 0);
    xfer(0, `REQ_IDX, 0); chk(rd, 32'h90);
    xfer(0, `EVT_STAT_IDX, 0); chk(rd[1], 1);
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed)) & `SEL_MASK;
      xfer(1, `SEL_IDX, {24'h0, v}); xfer(0, `SEL_IDX, 0); chk(rd, {24'h0, v});
      portAPins <= 5'($random(seed));
      portDPins <= 4'($random(seed));
      comparator1Out <= 1'($random(seed));
      repeat (4) @(posedge ref_clk);
      #1 chk(sharedReq, shExp(v, portAPins, portDPins, comparator1Out));
    end
    // Shared rising edge flags its event once the pins have settled low
    portAPins <= 5'h00;
    portDPins <= 4'h0;
    comparator1Out <= 1'b0;
    xfer(1, `SEL_IDX, 0);
    repeat (4) @(posedge ref_clk);
    xfer(1, `EVT_CLR_IDX, 32'h7);
    xfer(1, `EVT_EN_IDX, 32'h4);
    portAPins <= 5'h02;
    #1 chk(intOut, 0);
    repeat (4) @(posedge ref_clk);
    #1 chk(intOut, 1);
    xfer(0, `EVT_STAT_IDX, 0); chk(rd, 32'h4);
    chk(sharedReq, 5'h02);
    tallyAndFinish();
  end
endmodule : interrupt_request_and_master_enable_tb_top
